// >>> include/sfsc_pkg.sv
package sfsc_pkg;

  localparam int unsigned WORD_BITS = 24;
  localparam logic [23:0] DEFAULT_WORD_XTAL = 24'hbd097f;
  localparam logic [23:0] DEFAULT_WORD_TTL  = 24'hbc897f;

  // field positions inside the configuration word
  localparam int unsigned FB_DIV_LSB    = 0;
  localparam int unsigned FB_DIV_W      = 7;
  localparam int unsigned REF_DIV_LSB   = 7;
  localparam int unsigned REF_DIV_W     = 7;
  localparam int unsigned PRESCALE_BIT  = 14;
  localparam int unsigned AUX_SEL_LSB   = 15;
  localparam int unsigned POST_SEL_LSB  = 17;
  localparam int unsigned MAIN_EN_BIT   = 19;
  localparam int unsigned AUX_EN_BIT    = 20;
  localparam int unsigned RSVD_LO_BIT   = 21;
  localparam int unsigned REF_BYPASS_BIT = 22;
  localparam int unsigned RSVD_HI_BIT   = 23;

  // controller register map (word aligned byte offsets)
  localparam logic [31:0] REG_WORD_OFS   = 32'h0000_0000;
  localparam logic [31:0] REG_CTRL_OFS   = 32'h0000_0004;
  localparam logic [31:0] REG_STATUS_OFS = 32'h0000_0008;
  localparam int unsigned CTRL_START_BIT  = 0;
  localparam int unsigned CTRL_OE_BIT     = 1;
  localparam int unsigned CTRL_ABORT_BIT  = 2;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0002;

  // serial clock half period in core cycles, and load enable setup guard time
  localparam int unsigned SCLK_HALF_NS  = 40;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SCLK_HALF_CYC =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_NS  = 10;
  localparam int unsigned SETUP_CYC =
    (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SFSC_OUT_OFF, SFSC_OUT_VCO, SFSC_OUT_REF} sfsc_main_src_e;

endpackage : sfsc_pkg

// >>> include/sfsc_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sfsc_link_if;
  logic loadEnable_n;
  logic serialClk;
  logic serialData;
  logic outputEnablePin;
  modport device (input loadEnable_n, input serialClk, input serialData,
                  input outputEnablePin);
  modport host (output loadEnable_n, output serialClk, output serialData,
                output outputEnablePin);
endinterface : sfsc_link_if
`default_nettype wire

// >>> hw/sfsc_device.sv
// What this block and its controller must do
// R1: load enable low opens the shift register
// R2: sample data on rising serial clock, LSB first
// R3: 24th edge stops input, latches word
// R4: bits after the 24th are ignored
// R5: early release drops partial word, clears count
// R6: controller holds enable low 24 cycles
// R7: bits 0..6 are feedback divider N
// R8: bits 7..13 are reference divider M
// R9: bit 14 selects prescale 1 or 8
// R10: bits 15..16 select aux divider X
// R11: bits 17..18 select post divider R
// R12: bits 19, 20 enable main, aux outputs
// R13: controller writes reserved bits 21, 23 high; host sends them as software wrote them, high only in its reset word
// R14: bit 22 routes reference to main output
// R15: output drives only with pin and bit high
// R16: power-up preset to variant default word
// R17: new setting applies at 24th edge
// R18: VCO is N*V*ref/M, outputs by R, X
// R19: controller keeps M, VCO in recommended range; host sends M as written, with no range check
// R20: below 125 MHz use post divider two or more; host sends R as written, unchecked
// R21: enable high holds counter at zero
`timescale 1ns/1ns
`default_nettype none
module sfsc_device
  import sfsc_pkg::*;
#(
  parameter bit TTL_VARIANT = 1'b0
) (
  input  wire logic        core_clk,         // core clock
  input  wire logic        reset,            // synchronous power-up reset
  sfsc_link_if.device      link,             // serial load port
  output logic [6:0]       fbDivN,           // feedback divider N
  output logic [6:0]       refDivM,          // reference divider M
  output logic [3:0]       prescaleV,        // vco prescale 1 or 8
  output logic [3:0]       auxDivX,          // aux divider 1,2,4,8
  output logic [3:0]       postDivR,         // post divider 1,2,4,8
  output logic             refBypass,        // main output carries reference
  output logic             mainOutEnable_n,  // main output enable, low drives
  output logic             auxOutEnable_n,   // aux output enable, low drives
  output logic             settingChanged,   // one cycle pulse on new word
  output logic [23:0]      configWord        // latched configuration word
);

  typedef struct packed {
    logic [23:0] shiftReg;
    logic [4:0]  bitCount;
    logic        done;
    logic        sclkPrev;
    logic [23:0] latch;
    logic        changed;
  } sfsc_dev_s;

  sfsc_dev_s state;
  sfsc_dev_s next_state;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_state.sclkPrev = link.serialClk;
    next_state.changed  = 1'b0;
    if (link.loadEnable_n) begin
      // R5 discard partial
      // R21 idle counter zero
      next_state.bitCount = 5'h00;
      next_state.done     = 1'b0;
    // R1 shift enabled
    end else if (link.serialClk && !state.sclkPrev && !state.done) begin
      // R2 lsb first
      next_state.shiftReg = {link.serialData, state.shiftReg[23:1]};
      next_state.bitCount = state.bitCount + 5'h01;
      // R3 latch on 24th
      if (state.bitCount == 5'(WORD_BITS - 1)) begin
        // R4 stop accepting
        next_state.done    = 1'b1;
        // R17 apply at once
        next_state.latch   = {link.serialData, state.shiftReg[23:1]};
        next_state.changed = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= '0;
      // R16 power-up default
      state.latch <= TTL_VARIANT ? DEFAULT_WORD_TTL : DEFAULT_WORD_XTAL;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decoded settings; the analog loop outside computes vco = N*V*ref/M
  // R18 divider fields
  function automatic logic [3:0] sfsc_pow2(input logic [1:0] sel);
    sfsc_pow2 = 4'h1 << sel;
  endfunction : sfsc_pow2

  // R7 feedback divider
  assign fbDivN    = state.latch[FB_DIV_LSB +: FB_DIV_W];
  // R8 reference divider
  assign refDivM   = state.latch[REF_DIV_LSB +: REF_DIV_W];
  // R9 prescale select
  assign prescaleV = state.latch[PRESCALE_BIT] ? 4'h8 : 4'h1;
  // R10 aux divider
  assign auxDivX   = sfsc_pow2(state.latch[AUX_SEL_LSB +: 2]);
  // R11 post divider
  assign postDivR  = sfsc_pow2(state.latch[POST_SEL_LSB +: 2]);
  // R14 reference bypass
  assign refBypass = state.latch[REF_BYPASS_BIT];
  // R12 R15 output enables
  assign mainOutEnable_n = ~(link.outputEnablePin & state.latch[MAIN_EN_BIT]);
  assign auxOutEnable_n  = ~(link.outputEnablePin & state.latch[AUX_EN_BIT]);
  assign settingChanged  = state.changed;
  assign configWord      = state.latch;

endmodule : sfsc_device
`default_nettype wire

// >>> hw/sfsc_host.sv
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module sfsc_host
  import sfsc_pkg::*;
(
  input  wire logic        core_clk,   // core clock
  input  wire logic        reset,      // synchronous reset
  sfsc_link_if.host        link,       // serial load port
  input  wire logic [31:0] haddr,      // ahb address
  input  wire logic [1:0]  htrans,     // ahb transfer type
  input  wire logic        hwrite,     // ahb write
  input  wire logic [2:0]  hsize,      // ahb size
  input  wire logic [31:0] hwdata,     // ahb write data
  input  wire logic        hsel,       // ahb select
  input  wire logic        hready,     // ahb bus ready
  output logic [31:0]      hrdata,     // ahb read data
  output logic             hreadyout,  // ahb slave ready
  output logic             hresp       // ahb response, always okay
);

  typedef enum logic [1:0] {SFSC_IDLE, SFSC_SETUP, SFSC_LOW, SFSC_HIGH} sfsc_host_state_e;

  typedef struct packed {
    sfsc_host_state_e fsm;
    logic [23:0]      word;
    logic [23:0]      shift;
    logic [4:0]       bitsLeft;
    logic [3:0]       timer;
    logic             oe;
    logic             busy;
    logic             wrPend;
    logic [31:0]      wrAddr;
    logic             rdPend;
    logic [31:0]      rdAddr;
    logic [31:0]      rdata;
    logic             ceN;
    logic             sclk;
    logic             sdata;
  } sfsc_host_s;

  sfsc_host_s state;
  sfsc_host_s next_state;
  logic       startReq;
  logic       abortReq;

  //////////////////////////////////////////////////////////////////////////////
  // register writes land in the data phase; slave never waits
  always_comb begin
    next_state = state;
    startReq   = 1'b0;
    abortReq   = 1'b0;
    next_state.wrPend = 1'b0;
    next_state.rdPend = 1'b0;
    if (state.wrPend) begin
      if (state.wrAddr == REG_WORD_OFS) begin
        next_state.word = hwdata[23:0];
      end else if (state.wrAddr == REG_CTRL_OFS) begin
        next_state.oe = hwdata[CTRL_OE_BIT];
        startReq      = hwdata[CTRL_START_BIT];
        abortReq      = hwdata[CTRL_ABORT_BIT];
      end
    end
    if (hsel && hready && htrans[1]) begin
      next_state.wrPend = hwrite;
      next_state.wrAddr = haddr;
      next_state.rdPend = !hwrite;
      next_state.rdAddr = haddr;
    end
    if (state.timer != 4'h0) begin
      next_state.timer = state.timer - 4'h1;
    end
    // serial sequencer: setup, then 24 low/high serial clock cycles
    case (state.fsm)
      SFSC_IDLE: begin
        next_state.ceN  = 1'b1;
        next_state.sclk = 1'b0;
        if (startReq) begin
          next_state.busy     = 1'b1;
          next_state.ceN      = 1'b0;
          next_state.shift    = state.word;
          next_state.bitsLeft = 5'(WORD_BITS);
          next_state.timer    = 4'(SETUP_CYC);
          next_state.fsm      = SFSC_SETUP;
        end
      end
      SFSC_SETUP: begin
        if (state.timer == 4'h0) begin
          // R2 lsb first
          next_state.sdata = state.shift[0];
          next_state.timer = 4'(SCLK_HALF_CYC);
          next_state.fsm   = SFSC_LOW;
        end
      end
      SFSC_LOW: begin
        if (state.timer == 4'h0) begin
          next_state.sclk     = 1'b1;
          next_state.shift    = {1'b0, state.shift[23:1]};
          next_state.bitsLeft = state.bitsLeft - 5'h01;
          next_state.timer    = 4'(SCLK_HALF_CYC);
          next_state.fsm      = SFSC_HIGH;
        end
      end
      SFSC_HIGH: begin
        if (state.timer == 4'h0) begin
          next_state.sclk = 1'b0;
          next_state.timer = 4'(SCLK_HALF_CYC);
          // R6 hold enable 24 cycles
          if (state.bitsLeft == 5'h00) begin
            next_state.ceN  = 1'b1;
            next_state.busy = 1'b0;
            next_state.fsm  = SFSC_IDLE;
          end else begin
            next_state.sdata = state.shift[0];
            next_state.fsm   = SFSC_LOW;
          end
        end
      end
      default: next_state.fsm = SFSC_IDLE;
    endcase
    if (abortReq) begin
      next_state.ceN  = 1'b1;
      next_state.sclk = 1'b0;
      next_state.busy = 1'b0;
      next_state.fsm  = SFSC_IDLE;
    end
    // registered at the address edge so it stands through the data phase;
    // next values keep a back to back write then read coherent
    if (next_state.rdPend) begin
      case (next_state.rdAddr)
        REG_WORD_OFS:   next_state.rdata = {8'h00, next_state.word};
        REG_CTRL_OFS:   next_state.rdata = {29'h0, 1'b0, next_state.oe, 1'b0};
        REG_STATUS_OFS: next_state.rdata = {31'h0, next_state.busy};
        default:        next_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state      <= '0;
      state.fsm  <= SFSC_IDLE;
      state.ceN  <= 1'b1;
      // R13 R19 R20 reserved high, M and R in range
      state.word <= DEFAULT_WORD_XTAL;
      state.oe   <= CTRL_RESET[CTRL_OE_BIT];
    end else begin
      state <= next_state;
    end
  end

  assign hrdata    = state.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign link.loadEnable_n    = state.ceN;
  assign link.serialClk       = state.sclk;
  assign link.serialData      = state.sdata;
  assign link.outputEnablePin = state.oe;

endmodule : sfsc_host
`default_nettype wire

// >>> tb/sfsc_link_sva.sv
`timescale 1ns/1ns
`default_nettype none
module sfsc_link_sva (
  input wire logic        core_clk,        // clock
  input wire logic        reset,           // sync reset
  input wire logic        loadEnable_n,    // load enable
  input wire logic        serialClk,       // serial clock
  input wire logic        serialData,      // serial data
  input wire logic        outputEnablePin, // output enable pin
  input wire logic [23:0] configWord,      // latched word
  input wire logic        settingChanged,  // new word pulse
  input wire logic        mainOutEnable_n  // main output enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [5:0] edges;
  ////////////////////////////////////////////////////////////////
  // counts rising serial edges per frame, as the device sees them
  always_ff @(posedge core_clk) begin
    if (reset || loadEnable_n) edges <= 6'h00;
    else if (serialClk && !$past(serialClk)) edges <= edges + 6'h01;
  end
  a_frame_length: assert property ($rose(loadEnable_n) |-> edges == 6'h18)
    else $error("frame without 24 serial edges");
  a_latch_on_edge: assert property (!$stable(configWord) |-> edges == 6'h18)
    else $error("latch changed off the 24th edge");
  a_change_pulse: assert property (!$stable(configWord) |-> ##[0:1] settingChanged)
    else $error("no pulse on new word");
  a_pulse_single: assert property (settingChanged |=> !settingChanged)
    else $error("pulse longer than one cycle");
  a_tristate_pin: assert property (!outputEnablePin |-> mainOutEnable_n)
    else $error("main output drives with pin low");
  a_main_enable: assert property (outputEnablePin && configWord[19] |-> !mainOutEnable_n)
    else $error("main output not driving");
  a_setup_gap: assert property ($fell(loadEnable_n) |-> !serialClk [*2])
    else $error("serial clock too soon after enable");
  a_idle_low: assert property (loadEnable_n && $past(loadEnable_n) |-> !serialClk && edges == 6'h00)
    else $error("serial clock active while idle");
  c_load: cover property (settingChanged);
  c_frame: cover property ($rose(loadEnable_n));
  c_pin_off: cover property (!outputEnablePin);
endmodule : sfsc_link_sva
`default_nettype wire

// >>> tb/serial_freq_synth_config_tb.sv
`timescale 1ns/1ns
`default_nettype none
module serial_freq_synth_config_tb
  import sfsc_pkg::*;
;
  logic        core_clk = 1'h0;
  logic        reset = 1'h1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hwrite = 1'h0, hsel = 1'h0, hreadyout, hresp;
  logic [6:0]  fbDivN, refDivM;
  logic [3:0]  prescaleV, auxDivX, postDivR;
  logic        refBypass, mainOutEnable_n, auxOutEnable_n, settingChanged;
  logic [23:0] configWord, word2, w;
  int          fails = 0, checked = 0, cyc = 0;
  integer      seed = 32'hf0100071;
  sfsc_link_if link ();
  sfsc_link_if link2 ();
  sfsc_host sfsc_host_i (.core_clk, .reset, .link(link), .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hsel, .hready(hreadyout), .hrdata, .hreadyout, .hresp);
  sfsc_device sfsc_device_i (.core_clk, .reset, .link(link), .fbDivN, .refDivM, .prescaleV,
    .auxDivX, .postDivR, .refBypass, .mainOutEnable_n, .auxOutEnable_n, .settingChanged,
    .configWord);
  // second device faces the bench directly, so frames can break the rules
  sfsc_device #(.TTL_VARIANT(1'h1)) sfsc_device_i2 (.core_clk, .reset, .link(link2),
    .fbDivN(), .refDivM(), .prescaleV(), .auxDivX(), .postDivR(), .refBypass(),
    .mainOutEnable_n(), .auxOutEnable_n(), .settingChanged(), .configWord(word2));
  sfsc_link_sva sfsc_link_sva_i (.core_clk, .reset, .loadEnable_n(link.loadEnable_n),
    .serialClk(link.serialClk), .serialData(link.serialData),
    .outputEnablePin(link.outputEnablePin), .configWord, .settingChanged, .mainOutEnable_n);
  ////////////////////////////////////////////////////////////////
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [31:0] fld(input logic [23:0] x);
    return {5'h00, x[6:0], x[13:7], x[14] ? 4'h8 : 4'h1, 4'h1 << x[16:15],
            4'h1 << x[18:17], x[22]};
  endfunction : fld
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : ahb
  task automatic verify(input logic [23:0] x, input logic oe);
    chk({8'h00, configWord}, {8'h00, x});
    chk({5'h00, fbDivN, refDivM, prescaleV, auxDivX, postDivR, refBypass},
        fld(x));
    chk({30'h0, mainOutEnable_n, auxOutEnable_n},
        {30'h0, ~(oe & x[19]), ~(oe & x[20])});
  endtask : verify
  task automatic load(input logic [23:0] x);
    int n;
    ahb(1'h1, REG_WORD_OFS, {8'h00, x});
    ahb(1'h1, REG_CTRL_OFS, 32'h3);
    n = 0;
    do begin
      ahb(1'h0, REG_STATUS_OFS, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 200);
    verify(x, 1'h1);
  endtask : load
  // extra bits past 24 are the inverse of the word, so a leak shows
  task automatic shift(input logic [23:0] x, input int n);
    @(posedge core_clk);
    link2.loadEnable_n <= 1'h0;
    for (int b = 0; b < n; b++) begin
      @(posedge core_clk);
      link2.serialClk <= 1'h0;
      link2.serialData <= (b < 24) ? x[b] : ~x[b-24];
      repeat (2) @(posedge core_clk);
      link2.serialClk <= 1'h1;
      @(posedge core_clk);
    end
    @(posedge core_clk);
    link2.serialClk <= 1'h0;
    link2.loadEnable_n <= 1'h1;
    link2.serialData <= ~link2.serialData;
    repeat (3) @(posedge core_clk);
  endtask : shift
  ////////////////////////////////////////////////////////////////
  initial begin
    link2.loadEnable_n = 1'h1;
    link2.serialClk = 1'h0;
    link2.serialData = 1'h0;
    link2.outputEnablePin = 1'h1;
    repeat (12) @(posedge core_clk);
    reset <= 1'h0;
    @(posedge core_clk);
    verify(DEFAULT_WORD_XTAL, 1'h1);
    chk({8'h00, word2}, {8'h00, DEFAULT_WORD_TTL});
    ahb(1'h0, REG_CTRL_OFS, 32'h0);
    chk(rd, CTRL_RESET);
    ahb(1'h1, 32'h0000_0010, 32'hffff_ffff);
    ahb(1'h0, 32'h0000_0010, 32'h0);
    chk(rd, 32'h0);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      w = 24'($random(seed));
      w = {1'h1, i[1], 1'h1, ~i[2], i[2], ~i[1:0], i[1:0], i[0], w[13:0]};
      load(w);
    end
    load(24'hffffff);
    load(24'ha00000);
    load(24'hb80000);
    $display("test loads done");
    ahb(1'h1, REG_CTRL_OFS, 32'h0);
    ahb(1'h0, REG_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    verify(24'hb80000, 1'h0);
    $display("test enable pin done");
    shift(24'h5a5a5a, 10);
    chk({8'h00, word2}, {8'h00, DEFAULT_WORD_TTL});
    shift(24'ha5c3e1, 24);
    chk({8'h00, word2}, 32'h00a5c3e1);
    shift(24'hb00f0f, 30);
    chk({8'h00, word2}, 32'h00b00f0f);
    $display("test serial faults done");
    tally_and_finish();
  end
endmodule : serial_freq_synth_config_tb
`default_nettype wire
